// >>> rtc_supervisor.sv
`timescale 1ns/100ps
`default_nettype none

module rtc_supervisor
    import sup_pkg::*;
#(
    parameter int CLK_HZ     = CLK_HZ_DEF,
    parameter int TICK_HZ    = TICK_HZ_DEF,
    parameter int WPT_CYCLES = WPT_CYCLES_DEF
) (
    input  wire logic              MCLK,
    input  wire logic              SRST,
    input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [31:0]       AVS_WRITEDATA,
    input  wire logic [3:0]        AVS_BYTEENABLE,
    output logic      [31:0]       AVS_READDATA,
    output logic                   AVS_WAITREQUEST,
    input  wire logic              SUPPLY_ABOVE_POWER_FAIL_LEVEL,
    input  wire logic              BACKUP_MODE,
    input  wire logic              BACKUP_CELL_INPUT_OK,
    input  wire logic              WATCHDOG_KICK_IN,
    input  wire logic              WATCHDOG_FLOAT,
    input  wire logic              ALARM_MATCH,
    input  wire logic              CE_IN_N,
    output logic                   CE_OUT_N,
    input  wire logic              RST_I,
    output logic                   RST_O,
    output logic                   RST_OE,
    output logic                   INT_O,
    output logic                   INT_OE,
    output logic                   WATCHDOG_EXPIRED_OUT,
    output logic                   OSC_RUN,
    output logic                   WRITE_PROTECT
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] pins_level;
    logic       supply_ok;
    logic       backup;
    logic       cell_ok;
    logic       kick_level;
    logic       kick_float;
    logic       rst_pin;

    pin_sync #(
        .WIDTH (6)
    ) u_pins (
        .MCLK  (MCLK),
        .SRST  (SRST),
        .PIN   ({SUPPLY_ABOVE_POWER_FAIL_LEVEL, BACKUP_MODE, BACKUP_CELL_INPUT_OK,
                 WATCHDOG_KICK_IN, WATCHDOG_FLOAT, RST_I}),
        .LEVEL (pins_level)
    );

    assign {supply_ok, backup, cell_ok, kick_level, kick_float, rst_pin} = pins_level;

    // ------------------------------------------------------------
    // 32.768 kHz time base from the bus clock
    // ------------------------------------------------------------
    logic [31:0] tick_acc_reg;
    logic [31:0] tick_acc_sum;
    logic        tick;
    logic [31:0] tick_acc_next;

    assign tick_acc_sum  = tick_acc_reg + 32'(TICK_HZ);
    assign tick          = (tick_acc_sum >= 32'(CLK_HZ));
    assign tick_acc_next = tick ? tick_acc_sum - 32'(CLK_HZ) : tick_acc_sum;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [2:0]  wd_rate_reg;
    logic [3:0]  prd_rate_reg;
    logic [3:0]  enables_reg;
    logic        stop_reg;
    logic        alarm_flag_reg;
    logic        periodic_flag_reg;
    logic        pfail_flag_reg;

    // ------------------------------------------------------------
    // bus slave: a request is answered only once its address has
    // stood still, so a glitch never clears the flags
    // ------------------------------------------------------------
    logic              req;
    logic [ADDR_W-1:0] addr_prev_reg;
    logic [1:0]        hold_reg;
    logic [1:0]        hold_next;
    logic              hold_done;
    logic              accept;
    logic [3:0]        idx;
    logic              hit_rates;
    logic              hit_enables;
    logic              hit_flags;
    logic              hit_control;
    logic [7:0]        rd_byte;
    logic              wr_en;
    logic              flags_clear;
    logic              wp;

    assign req       = AVS_READ | AVS_WRITE;
    assign idx       = AVS_ADDRESS[ADDR_W-1:2];
    assign hit_rates   = (idx == IDX_RATES);
    assign hit_enables = (idx == IDX_ENABLES);
    assign hit_flags   = (idx == IDX_FLAGS);
    assign hit_control = (idx == IDX_CONTROL);
    assign hold_done = (hold_reg == 2'(ADDR_HOLD_CYCLES));
    assign hold_next = (!req || !AVS_WAITREQUEST || AVS_ADDRESS != addr_prev_reg) ? 2'h0 :
                       hold_done ? hold_reg : hold_reg + 2'h1;
    assign accept    = req && !AVS_WAITREQUEST;
    assign wr_en     = accept && AVS_WRITE && AVS_BYTEENABLE[0] && !wp;
    assign flags_clear = accept && AVS_READ && hit_flags;

    always_comb
    begin
        rd_byte = 8'h00;
        if (hit_rates)
            rd_byte = {1'b0, wd_rate_reg, prd_rate_reg};
        else if (hit_enables)
            rd_byte = {4'h0, enables_reg};
        else if (hit_flags)
            rd_byte = {4'h0, alarm_flag_reg, periodic_flag_reg, pfail_flag_reg, cell_ok};
        else if (hit_control)
            rd_byte = {5'h00, stop_reg, 2'h0};
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h0000_0000;
            hold_reg        <= 2'h0;
            addr_prev_reg   <= '0;
        end
        else
        begin
            AVS_WAITREQUEST <= !(req && AVS_WAITREQUEST && hold_done);
            if (req && AVS_WAITREQUEST && hold_done)
                AVS_READDATA <= {24'h000000, rd_byte};
            hold_reg      <= hold_next;
            addr_prev_reg <= AVS_ADDRESS;
        end
    end

    // ------------------------------------------------------------
    // power sequence
    // ------------------------------------------------------------
    pwr_state_e       pwr_reg;
    pwr_state_e       pwr_next;
    logic [31:0]      grace_reg;
    logic [CNT_W-1:0] rec_reg;
    logic             ce_block_reg;
    logic             ce_in_level;
    logic             ce_in_s1_reg;
    logic             ce_in_s2_reg;
    logic             ce_in_s3_reg;
    logic             grace_over;
    logic             rec_over;
    logic             pfail_event;

    assign grace_over  = (grace_reg >= 32'(WPT_CYCLES - 1));
    assign rec_over    = (rec_reg == CNT_W'(RECOVERY_TICKS));
    assign pfail_event = (pwr_reg == PWR_VALID) && !supply_ok;
    assign wp          = (pwr_reg != PWR_VALID);
    assign ce_in_level = (ce_in_s2_reg == ce_in_s3_reg) ? ce_in_s3_reg : 1'b0;

    always_comb
    begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            PWR_VALID:
                if (!supply_ok)
                    pwr_next = PWR_GRACE;
            PWR_GRACE:
                if (grace_over)
                    pwr_next = PWR_DOWN;
            PWR_DOWN:
                if (supply_ok)
                    pwr_next = PWR_RECOVER;
            PWR_RECOVER:
                if (!supply_ok)
                    pwr_next = PWR_DOWN;
                else if (rec_over)
                    pwr_next = PWR_VALID;
            default:
                pwr_next = PWR_DOWN;
        endcase
    end

    // combinational path kept so valid-power delay is a gate, not a clock
    assign CE_OUT_N = CE_IN_N | ce_block_reg;

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            pwr_reg      <= PWR_DOWN;
            grace_reg    <= 32'h0000_0000;
            rec_reg      <= '0;
            ce_block_reg <= 1'b1;
            ce_in_s1_reg <= 1'b1;
            ce_in_s2_reg <= 1'b1;
            ce_in_s3_reg <= 1'b1;
        end
        else
        begin
            pwr_reg      <= pwr_next;
            ce_in_s1_reg <= CE_IN_N;
            ce_in_s2_reg <= ce_in_s1_reg;
            ce_in_s3_reg <= ce_in_s2_reg;
            grace_reg    <= (pwr_reg == PWR_GRACE) ? grace_reg + 32'h1 : 32'h0;
            if (pwr_reg != PWR_RECOVER)
                rec_reg <= '0;
            else if (tick && !rec_over)
                rec_reg <= rec_reg + CNT_W'(1);
            // idle enable gates at once; a running access keeps it
            if (pwr_reg == PWR_VALID && pwr_next == PWR_VALID)
                ce_block_reg <= 1'b0;
            else if (pwr_reg == PWR_GRACE && ce_in_level)
                ce_block_reg <= 1'b1;
            else if (pwr_next != PWR_GRACE)
                ce_block_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    logic [CNT_W-1:0] wd_cnt_reg;
    logic [CNT_W-1:0] wd_limit;
    logic [CNT_W-1:0] wd_width;
    logic [2:0]       wd_shift;
    logic             kick_prev_reg;
    logic             kick;
    logic             wd_en;
    logic             wd_timeout;
    logic [CNT_W-1:0] pulse_reg;
    logic             pulse_on;
    logic             rst_drive;

    assign wd_shift = wd_rate_reg - 3'h1;
    assign wd_limit = (wd_rate_reg == WD_RATE_RST)  ? CNT_W'(WD_DEF_TICKS) :
                      (wd_rate_reg == WD_CODE_LONG) ? CNT_W'(WD_LONG_TICKS) :
                      CNT_W'(WD_BASE_TICKS) << wd_shift;
    assign wd_width = (wd_rate_reg == WD_RATE_RST)  ? CNT_W'(WD_DEF_RST_TICKS) :
                      (wd_rate_reg == WD_CODE_LONG) ? CNT_W'(WD_LONG_RST_TICKS) :
                      CNT_W'(WD_RST_BASE_TICKS) << wd_shift;
    assign kick       = (kick_level != kick_prev_reg);
    assign wd_en      = (pwr_reg == PWR_VALID) && !backup && !kick_float;
    assign pulse_on   = (pulse_reg != '0);
    assign rst_drive  = pulse_on || (pwr_reg == PWR_DOWN) || (pwr_reg == PWR_RECOVER);
    assign wd_timeout = wd_en && !rst_drive && tick && (wd_cnt_reg >= wd_limit - CNT_W'(1));

    // ------------------------------------------------------------
    // push button: the pin is only judged while nobody drives it
    // ------------------------------------------------------------
    logic [4:0] btn_cnt_reg;
    logic       btn_long;
    logic       btn_release;

    assign btn_long    = (btn_cnt_reg == 5'(BTN_MIN_CYCLES));
    assign btn_release = rst_pin && btn_long;

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            kick_prev_reg        <= 1'b0;
            wd_cnt_reg           <= '0;
            pulse_reg            <= '0;
            btn_cnt_reg          <= 5'h00;
            WATCHDOG_EXPIRED_OUT <= 1'b1;
            RST_OE               <= 1'b1;
        end
        else
        begin
            kick_prev_reg <= kick_level;
            // count cleared while reset drives, so each reset starts a full period
            if (!wd_en || kick || rst_drive || wd_timeout)
                wd_cnt_reg <= '0;
            else if (tick)
                wd_cnt_reg <= wd_cnt_reg + CNT_W'(1);
            if (!wd_en || kick)
                WATCHDOG_EXPIRED_OUT <= 1'b1;
            else if (wd_timeout)
                WATCHDOG_EXPIRED_OUT <= 1'b0;
            if (wd_timeout)
                pulse_reg <= wd_width;
            else if (btn_release && (pwr_reg == PWR_VALID))
                pulse_reg <= CNT_W'(BTN_PULSE_TICKS);
            else if (tick && pulse_on)
                pulse_reg <= pulse_reg - CNT_W'(1);
            if (rst_drive || rst_pin || RST_OE)
                btn_cnt_reg <= 5'h00;
            else if (!btn_long)
                btn_cnt_reg <= btn_cnt_reg + 5'h01;
            RST_OE <= rst_drive || wd_timeout;
        end
    end

    // ------------------------------------------------------------
    // event flags and interrupt
    // ------------------------------------------------------------
    logic [PRD_CNT_W-1:0] prd_cnt_reg;
    logic [PRD_CNT_W-1:0] prd_mask;
    logic                 prd_event;
    logic                 irq_any;
    logic                 irq_backup;

    assign prd_mask  = PRD_CNT_W'((15'h0001 << (prd_rate_reg - 4'h1)) - 15'h0001);
    assign prd_event = tick && (prd_rate_reg != PRD_CODE_NONE)
                       && ((prd_cnt_reg & prd_mask) == '0);
    assign irq_any   = (alarm_flag_reg && enables_reg[BIT_ALARM])
                       || (periodic_flag_reg && enables_reg[BIT_PERIODIC])
                       || (pfail_flag_reg && enables_reg[BIT_PFAIL]);
    assign irq_backup = alarm_flag_reg && enables_reg[BIT_ALARM] && enables_reg[BIT_LOWEST];

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            tick_acc_reg      <= 32'h0000_0000;
            prd_cnt_reg       <= '0;
            alarm_flag_reg    <= 1'b0;
            periodic_flag_reg <= 1'b0;
            pfail_flag_reg    <= 1'b0;
            INT_OE            <= 1'b0;
            RST_O             <= 1'b0;
            INT_O             <= 1'b0;
        end
        else
        begin
            tick_acc_reg <= tick_acc_next;
            if (tick)
                prd_cnt_reg <= prd_cnt_reg + PRD_CNT_W'(1);
            // a new event beats a clearing read in the same cycle
            alarm_flag_reg    <= ALARM_MATCH || (alarm_flag_reg && !flags_clear);
            periodic_flag_reg <= prd_event || (periodic_flag_reg && !flags_clear);
            pfail_flag_reg    <= pfail_event || (pfail_flag_reg && !flags_clear);
            if (flags_clear)
                INT_OE <= 1'b0;
            else if (backup || pwr_reg == PWR_DOWN)
                INT_OE <= irq_backup;
            else
                INT_OE <= irq_any;
            RST_O <= 1'b0;
            INT_O <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register writes, oscillator, write protect
    // ------------------------------------------------------------
    logic lose_data;

    // without a good cell the retained fields do not survive power down
    assign lose_data = (pwr_reg == PWR_DOWN) && !cell_ok;

    always_ff @(posedge MCLK)
    begin
        if (SRST || lose_data)
        begin
            wd_rate_reg  <= WD_RATE_RST;
            prd_rate_reg <= PRD_RATE_RST;
            enables_reg  <= ENABLES_RST;
            stop_reg     <= STOP_RST;
        end
        else if (wr_en)
        begin
            if (hit_rates)
            begin
                wd_rate_reg  <= AVS_WRITEDATA[RATE_WD_MSB:RATE_WD_LSB];
                prd_rate_reg <= AVS_WRITEDATA[RATE_PRD_MSB:RATE_PRD_LSB];
            end
            else if (hit_enables)
                enables_reg <= AVS_WRITEDATA[BIT_ALARM:BIT_LOWEST];
            else if (hit_control)
                stop_reg <= AVS_WRITEDATA[CTL_STOP];
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            OSC_RUN       <= 1'b1;
            WRITE_PROTECT <= 1'b1;
        end
        else
        begin
            OSC_RUN       <= !backup || stop_reg;
            WRITE_PROTECT <= wp || (pwr_next != PWR_VALID);
        end
    end

endmodule // rtc_supervisor

`default_nettype wire

// >>> sup_pkg.sv
package sup_pkg;

    // ------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int CLK_HZ_DEF    = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int TICK_HZ_DEF   = 32768;
    localparam int CNT_W         = 17;

    // ------------------------------------------------------------
    // register map: index, byte address is four times the index
    // ------------------------------------------------------------
    localparam int         ADDR_W      = 6;
    localparam logic [3:0] IDX_RATES   = 4'hb;
    localparam logic [3:0] IDX_ENABLES = 4'hc;
    localparam logic [3:0] IDX_FLAGS   = 4'hd;
    localparam logic [3:0] IDX_CONTROL = 4'he;

    localparam int RATE_WD_MSB  = 6;
    localparam int RATE_WD_LSB  = 4;
    localparam int RATE_PRD_MSB = 3;
    localparam int RATE_PRD_LSB = 0;
    // same bit order in the enables and flags registers
    localparam int BIT_ALARM    = 3;
    localparam int BIT_PERIODIC = 2;
    localparam int BIT_PFAIL    = 1;
    localparam int BIT_LOWEST   = 0;
    localparam int CTL_STOP     = 2;

    localparam logic [2:0] WD_RATE_RST   = 3'h0;
    localparam logic [3:0] PRD_RATE_RST  = 4'h0;
    localparam logic [3:0] ENABLES_RST   = 4'h0;
    localparam logic       STOP_RST      = 1'b0;
    localparam logic [2:0] WD_CODE_LONG  = 3'h7;
    localparam logic [3:0] PRD_CODE_NONE = 4'h0;
    localparam int         PRD_CNT_W     = 14;

    // ------------------------------------------------------------
    // timing, times in their own unit, counts derived
    // ------------------------------------------------------------
    localparam int ADDR_HOLD_NS     = 50;
    localparam int ADDR_HOLD_CYCLES = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BTN_MIN_NS       = 1000;
    localparam int BTN_MIN_CYCLES   = (BTN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPT_NS_DEF       = 10000;
    localparam int WPT_CYCLES_DEF   = WPT_NS_DEF / CLK_PERIOD_NS;

    localparam int RECOVERY_MS      = 200;
    localparam int RECOVERY_TICKS   = int'(longint'(RECOVERY_MS) * TICK_HZ_DEF / 1000);
    localparam int BTN_PULSE_MS     = 200;
    localparam int BTN_PULSE_TICKS  = int'(longint'(BTN_PULSE_MS) * TICK_HZ_DEF / 1000);

    localparam longint WD_BASE_NS   = 23437500;
    localparam int WD_BASE_TICKS    = int'(WD_BASE_NS * TICK_HZ_DEF / 1_000_000_000);
    localparam int WD_RST_BASE_TICKS = WD_BASE_TICKS / 6;
    localparam int WD_DEF_MS        = 1500;
    localparam int WD_DEF_TICKS     = int'(longint'(WD_DEF_MS) * TICK_HZ_DEF / 1000);
    localparam int WD_DEF_RST_US    = 250;
    localparam int WD_DEF_RST_TICKS =
        int'((longint'(WD_DEF_RST_US) * TICK_HZ_DEF + 999_999) / 1_000_000);
    localparam int WD_LONG_MS       = 3000;
    localparam int WD_LONG_TICKS    = int'(longint'(WD_LONG_MS) * TICK_HZ_DEF / 1000);
    localparam int WD_LONG_RST_MS   = 500;
    localparam int WD_LONG_RST_TICKS = int'(longint'(WD_LONG_RST_MS) * TICK_HZ_DEF / 1000);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_VALID,
        PWR_GRACE,
        PWR_DOWN,
        PWR_RECOVER
    } pwr_state_e;

endpackage

// >>> pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

// three-stage synchroniser; the output follows once stages two and three agree
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             MCLK,
    input  wire logic             SRST,
    input  wire logic [WIDTH-1:0] PIN,
    output logic      [WIDTH-1:0] LEVEL
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_next;

    assign level_next = (s2_reg == s3_reg) ? s3_reg : LEVEL;

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            LEVEL  <= '0;
        end
        else
        begin
            s1_reg <= PIN;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            LEVEL  <= level_next;
        end
    end

endmodule // pin_sync

`default_nettype wire

// >>> host_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_side_model (
    input  wire logic MCLK,
    input  wire logic kick_en,
    input  wire logic rst_oe,
    input  wire logic press,
    output logic      kick,
    output logic      rst_line
);
    logic [6:0] cnt_reg = 7'h0;
    // kick every 64 cycles, well inside the shortest period
    always @(posedge MCLK) cnt_reg <= cnt_reg + 7'h1;
    always @(posedge MCLK) kick <= kick_en ? cnt_reg[6] : kick;
    initial kick = 1'b0;
    // pull-up on the line; a pressed button pulls it low like the device does
    assign rst_line = ~(rst_oe | press);
endmodule // host_side_model
`default_nettype wire

// >>> rtc_supervisor_checker.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_supervisor_checker
    import sup_pkg::*;
#(
    parameter int WPT_CYCLES = WPT_CYCLES_DEF
) (
    input wire logic              MCLK,
    input wire logic              SRST,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input wire logic              AVS_READ,
    input wire logic              AVS_WAITREQUEST,
    input wire logic              BACKUP_MODE,
    input wire logic              CE_IN_N,
    input wire logic              CE_OUT_N,
    input wire logic              RST_OE,
    input wire logic              INT_OE,
    input wire logic              WATCHDOG_EXPIRED_OUT,
    input wire logic              OSC_RUN,
    input wire logic              WRITE_PROTECT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    localparam int GRACE_LATE = WPT_CYCLES + 10;
    property p_ce_pass; !WRITE_PROTECT && !RST_OE |-> CE_OUT_N == CE_IN_N; endproperty
    a_ce_pass: assert property (p_ce_pass) else $error("sram enable not passed");
    property p_ce_block; WRITE_PROTECT && RST_OE |-> CE_OUT_N; endproperty
    a_ce_block: assert property (p_ce_block) else $error("sram enable not blocked");
    property p_grace; $rose(WRITE_PROTECT) |-> !RST_OE[*8] ##[1:GRACE_LATE] RST_OE; endproperty
    a_grace: assert property (p_grace) else $error("grace interval wrong");
    property p_wdo_off; BACKUP_MODE[*6] |-> WATCHDOG_EXPIRED_OUT; endproperty
    a_wdo_off: assert property (p_wdo_off) else $error("watchdog out low in backup");
    property p_wdo_rst; $fell(WATCHDOG_EXPIRED_OUT) |-> RST_OE; endproperty
    a_wdo_rst: assert property (p_wdo_rst) else $error("timeout without reset");
    property p_addr_hold; $fell(AVS_WAITREQUEST) |-> AVS_ADDRESS == $past(AVS_ADDRESS, 2); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("answer on unstable address");
    property p_int_clear;
        $fell(AVS_WAITREQUEST) && AVS_READ && AVS_ADDRESS[5:2] == IDX_FLAGS |-> ##2 !INT_OE;
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("interrupt kept after read");
    property p_osc; (!BACKUP_MODE)[*6] |-> OSC_RUN; endproperty
    a_osc: assert property (p_osc) else $error("oscillator halted on main supply");
endmodule // rtc_supervisor_checker
bind rtc_supervisor rtc_supervisor_checker #(.WPT_CYCLES(WPT_CYCLES)) chk_u (
    .MCLK(MCLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .BACKUP_MODE(BACKUP_MODE), .CE_IN_N(CE_IN_N),
    .CE_OUT_N(CE_OUT_N), .RST_OE(RST_OE), .INT_OE(INT_OE), .OSC_RUN(OSC_RUN),
    .WATCHDOG_EXPIRED_OUT(WATCHDOG_EXPIRED_OUT), .WRITE_PROTECT(WRITE_PROTECT));
`default_nettype wire

// >>> rtc_supervisor_watchdog_irq_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_supervisor_watchdog_irq_bench;
    import sup_pkg::*;
    logic        mclk = 0, srst = 1, rd = 0, wr = 0, sup = 0, bkp = 0, flt = 0, cei = 1, ken = 1;
    logic        psh = 0, cel = 1, alm = 0;
    logic [5:0]  adr = 6'h0;
    logic [31:0] wdat = 32'h0, q, rdat;
    logic        wt, ceo, rsti, rsto, rstoe, into, intoe, watchdog_expired_out, osc, wp, kick;
    int          bad_count = 0, cmp_count = 0, n;
    initial forever #20 mclk = ~mclk;
    // one tick per cycle keeps watchdog and recovery counts short
    rtc_supervisor #(.TICK_HZ(CLK_HZ_DEF), .WPT_CYCLES(20)) dut_u (
        .MCLK(mclk), .SRST(srst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt),
        .SUPPLY_ABOVE_POWER_FAIL_LEVEL(sup), .BACKUP_MODE(bkp), .BACKUP_CELL_INPUT_OK(cel),
        .WATCHDOG_KICK_IN(kick), .WATCHDOG_FLOAT(flt), .ALARM_MATCH(alm), .CE_IN_N(cei),
        .CE_OUT_N(ceo), .RST_I(rsti), .RST_O(rsto), .RST_OE(rstoe), .INT_O(into),
        .INT_OE(intoe), .WATCHDOG_EXPIRED_OUT(watchdog_expired_out), .OSC_RUN(osc), .WRITE_PROTECT(wp));
    host_side_model host_u (.MCLK(mclk), .kick_en(ken), .rst_oe(rstoe), .press(psh),
        .kick(kick), .rst_line(rsti));
    task automatic chk(string s, logic [31:0] e, logic [31:0] v);
        cmp_count++;
        if (v !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic hang(int k, int lim);
        if (k >= lim)
        begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic bus(logic w, logic [5:0] a, logic [7:0] d);
        int k;
        @(posedge mclk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= {24'h0, d};
        for (k = 0; k < 50 && wt !== 1'b0; k++) @(posedge mclk);
        q = rdat;
        hang(k, 50);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic waitfor(logic s, logic v, int lim);
        for (n = 0; n < lim && (s ? watchdog_expired_out : rstoe) !== v; n++) @(posedge mclk);
        hang(n, lim);
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        chk("reset line", 1, rstoe);
        chk("drive levels", 0, {rsto, into});
        chk("sram enable", 1, ceo);
        sup <= 1'b1;
        waitfor(0, 0, 7000);
        chk("recovery", 1, n >= 6553 && n < 6600);
        cei <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("sram pass", 0, ceo);
        bus(1, 6'h2c, 8'h10);
        bus(0, 6'h2c, 8'h0);
        chk("rates", 32'h10, q);
        bus(0, 6'h00, 8'h0);
        chk("unmapped", 0, q);
        alm <= 1'b1;
        @(posedge mclk);
        alm <= 1'b0;
        bus(0, 6'h34, 8'h0);
        chk("flags", 32'h9, q);
        psh <= 1'b1;
        repeat (40) @(posedge mclk);
        psh <= 1'b0;
        waitfor(0, 1, 20);
        waitfor(0, 0, 7000);
        chk("button pulse", 1, n > 6540 && n < 6570);
        $display("power-up test end");
        ken <= 1'b0;
        waitfor(1, 0, 1000);
        chk("wd silence", 1, n > 690 && n < 800);
        chk("wd reset", 1, rstoe);
        waitfor(0, 0, 200);
        chk("wd pulse", 1, n > 124 && n < 132);
        waitfor(0, 1, 900);
        chk("wd repeat", 1, n > 760 && n < 776);
        chk("wd out", 0, watchdog_expired_out);
        ken <= 1'b1;
        waitfor(1, 1, 300);
        flt <= 1'b1;
        ken <= 1'b0;
        repeat (1000) @(posedge mclk);
        chk("wd float", 1, watchdog_expired_out);
        chk("wd float rst", 0, rstoe);
        flt <= 1'b0;
        ken <= 1'b1;
        $display("watchdog test end");
        bus(1, 6'h30, 8'h02);
        sup <= 1'b0;
        repeat (7) @(posedge mclk);
        chk("pf protect", 1, wp);
        chk("pf irq", 1, intoe);
        chk("pf access", 0, ceo);
        bus(0, 6'h34, 8'h0);
        chk("pf flags", 32'h3, q);
        repeat (2) @(posedge mclk);
        chk("irq clear", 0, intoe);
        waitfor(0, 1, 40);
        chk("pf grace", 1, ceo);
        bus(1, 6'h2c, 8'h20);
        bus(0, 6'h2c, 8'h0);
        chk("pf write", 32'h10, q);
        bus(0, 6'h34, 8'h0);
        chk("flags clear", 32'h1, q);
        bkp <= 1'b1;
        repeat (8) @(posedge mclk);
        chk("osc stop", 0, osc);
        bkp <= 1'b0;
        sup <= 1'b1;
        waitfor(0, 0, 7000);
        bus(0, 6'h2c, 8'h0);
        chk("rates kept", 32'h10, q);
        cel <= 1'b0;
        sup <= 1'b0;
        waitfor(0, 1, 40);
        sup <= 1'b1;
        waitfor(0, 0, 7000);
        bus(0, 6'h2c, 8'h0);
        chk("rates lost", 0, q);
        $display("power-fail test end");
        complete_run();
    end
endmodule // rtc_supervisor_watchdog_irq_bench
`default_nettype wire
